// >>> rtl/asr_pkg.sv
package asr_pkg;
  localparam logic [7:0] ADDR_BAUD    = 8'hE0;
  localparam logic [7:0] ADDR_TXFINE  = 8'hE4;
  localparam logic [7:0] ADDR_RXFINE  = 8'hE8;
  localparam logic [7:0] ADDR_STATUS  = 8'hF0;
  localparam logic [7:0] ADDR_DATA    = 8'hF4;
  localparam logic [7:0] ADDR_CTL1    = 8'hF8;
  localparam logic [7:0] ADDR_CTL2    = 8'hFC;
  localparam logic [7:0] STATUS_RESET = 8'hC0;
  localparam logic [7:0] CTL_RESET    = 8'h00;
  // Control 1 fields
  localparam int C1_T8 = 6;
  localparam int C1_M  = 4;
  localparam int C1_WK = 3;
  localparam int C1_PC = 2;
  localparam int C1_PS = 1;
  localparam int C1_PI = 0;
  // Control 2 fields
  localparam int C2_TIE = 7;
  localparam int C2_TCI = 6;
  localparam int C2_RIE = 5;
  localparam int C2_ILI = 4;
  localparam int C2_TE  = 3;
  localparam int C2_RE  = 2;
  localparam int C2_RWU = 1;
  localparam int C2_SBK = 0;
  // Coarse divisors 1, 3, 4, 13
  localparam logic [3:0] COARSE_0 = 4'h1;
  localparam logic [3:0] COARSE_1 = 4'h3;
  localparam logic [3:0] COARSE_2 = 4'h4;
  localparam logic [3:0] COARSE_3 = 4'hD;
  // Oversampling: 16 ticks a bit, mid-bit at 7
  localparam logic [3:0] OS_LAST  = 4'hF;
  localparam logic [3:0] OS_MID   = 4'h7;
  localparam logic [3:0] LEN8     = 4'hA;
  localparam logic [3:0] LEN9     = 4'hB;
  localparam logic [7:0] IDLE8    = 8'hA0;
  localparam logic [7:0] IDLE9    = 8'hB0;
  typedef enum logic [1:0] {RX_IDLE = 2'b00, RX_START = 2'b01, RX_DATA = 2'b10, RX_STOP = 2'b11} asr_rx_type;
  typedef enum logic [0:0] {TX_IDLE = 1'b0, TX_RUN = 1'b1} asr_tx_type;
endpackage

// >>> rtl/asr_top.sv
`timescale 1ns/1ps
module asr_top
  import asr_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        rx_in,
  output logic             tx_out,
  output logic             tx_oe_n,
  output logic             irq_req
);

  function automatic logic par8(input logic [7:0] d);
    par8 = ^d;
  endfunction

  function automatic logic [10:0] tx_frame(input logic [8:0] d, input logic m, input logic pc, input logic ps);
    logic [8:0] w;
    w = d;
    if (pc && m) begin
      w[8] = par8(d[7:0]) ^ ps;
    end else if (pc) begin
      w[7] = par8({1'b0, d[6:0]}) ^ ps;
    end
    tx_frame = m ? {1'b1, w, 1'b0} : {2'b11, w[7:0], 1'b0};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Registers and bus
  logic       ack_reg, seq_reg, rwu_reg, irq_reg;
  logic [31:0] dat_reg;
  logic [6:0] ctl1_reg;
  logic [7:0] ctl2_reg, baud_reg, txf_reg, rxf_reg;
  logic       tx_empty_flag_reg, tc_reg, rx_word_ready_flag_reg, idle_reg, or_reg, fe_reg, pe_reg;
  logic [8:0] rhold_reg, thold_reg;
  logic       tfull_reg, armed_reg;

  wire        acc     = wb_cyc_i & wb_stb_i & ~ack_reg;
  wire        wr      = acc & wb_we_i & wb_sel_i[0];
  wire        rd      = acc & ~wb_we_i;
  wire        hit_st  = wb_adr_i == ADDR_STATUS;
  wire        hit_dt  = wb_adr_i == ADDR_DATA;
  wire        hit_c1  = wb_adr_i == ADDR_CTL1;
  wire        hit_c2  = wb_adr_i == ADDR_CTL2;
  wire        hit_bd  = wb_adr_i == ADDR_BAUD;
  wire        hit_tf  = wb_adr_i == ADDR_TXFINE;
  wire        hit_rf  = wb_adr_i == ADDR_RXFINE;
  wire        rx_clr  = rd & hit_dt & seq_reg;
  wire        tx_clr  = wr & hit_dt & seq_reg;
  wire        c2_wr   = wr & hit_c2;
  wire [7:0]  status  = {tx_empty_flag_reg, tc_reg, rx_word_ready_flag_reg, idle_reg, or_reg, 1'b0, fe_reg, pe_reg};
  wire        m_bit   = ctl1_reg[C1_M];
  wire        rx_en   = ctl2_reg[C2_RE];
  wire        te      = ctl2_reg[C2_TE];
  wire [7:0]  c2_view = {ctl2_reg[7:2], rwu_reg, ctl2_reg[C2_SBK]};
  wire [7:0]  rd_mux;

  assign rd_mux = hit_st ? status :
                  hit_dt ? rhold_reg[7:0] :
                  hit_c1 ? {rhold_reg[8], ctl1_reg} :
                  hit_c2 ? c2_view :
                  hit_bd ? baud_reg :
                  hit_tf ? txf_reg :
                  hit_rf ? rxf_reg : 8'h00;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h0000_0000;
      seq_reg <= 1'b0;
    end else begin
      ack_reg <= acc;
      dat_reg <= acc ? {24'h00_0000, rd_mux} : dat_reg;
      seq_reg <= acc ? hit_st : seq_reg;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctl1_reg <= CTL_RESET[6:0];
      ctl2_reg <= CTL_RESET;
      baud_reg <= CTL_RESET;
      txf_reg  <= CTL_RESET;
      rxf_reg  <= CTL_RESET;
    end else begin
      if (wr && hit_c1) ctl1_reg <= wb_dat_i[6:0];
      if (c2_wr) ctl2_reg <= wb_dat_i[7:0];
      if (wr && hit_bd) baud_reg <= wb_dat_i[7:0];
      if (wr && hit_tf) txf_reg <= wb_dat_i[7:0];
      if (wr && hit_rf) rxf_reg <= wb_dat_i[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Baud generation, index 0 transmit, 1 receive
  logic [3:0] co_reg;
  logic [3:0] co_div;
  wire  [1:0] os_tick;
  wire        co_tick = co_reg == co_div - 4'h1;

  assign co_div = (baud_reg[7:6] == 2'b00) ? COARSE_0 :
                  (baud_reg[7:6] == 2'b01) ? COARSE_1 :
                  (baud_reg[7:6] == 2'b10) ? COARSE_2 : COARSE_3;

  always_ff @(posedge sys_clk) begin
    if (rst) co_reg <= 4'h0;
    else co_reg <= co_tick ? 4'h0 : co_reg + 4'h1;
  end

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_dir
      logic [6:0] p2_reg;
      logic [7:0] fn_reg;
      wire  [2:0] sel  = g == 0 ? baud_reg[5:3] : baud_reg[2:0];
      wire  [7:0] fac  = g == 0 ? txf_reg : rxf_reg;
      wire  [6:0] mask = 7'((8'h01 << sel) - 8'h01);
      wire        hit  = co_tick && ((p2_reg & mask) == mask);
      // Oversampling tick: 16 of them make one bit
      assign os_tick[g] = hit && (fac == 8'h00 || fn_reg == fac - 8'h01);
      always_ff @(posedge sys_clk) begin
        if (rst) begin
          p2_reg <= 7'h00;
          fn_reg <= 8'h00;
        end else begin
          p2_reg <= co_tick ? p2_reg + 7'h01 : p2_reg;
          fn_reg <= os_tick[g] ? 8'h00 : hit ? fn_reg + 8'h01 : fn_reg;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Transmitter
  asr_tx_type  tx_st_reg;
  logic [10:0] tsh_reg;
  logic [3:0]  tbits_reg, tos_reg;
  logic        te_prev_reg, idle_pend_reg, tout_reg, oe_n_reg;
  wire         tx_start = te && tx_st_reg == TX_IDLE;
  // Preamble owed from the cycle TE rises, ahead of any waiting word
  wire         pre_due  = idle_pend_reg || (te && !te_prev_reg);
  wire         tx_brk   = tx_start && ctl2_reg[C2_SBK];
  wire         tx_pre   = tx_start && !tx_brk && pre_due;
  wire         tx_load  = tx_start && !tx_brk && !pre_due && tfull_reg;
  wire         tx_shift = tx_st_reg == TX_RUN && os_tick[0] && tos_reg == OS_LAST;
  wire         tx_done  = tx_shift && tbits_reg == 4'h1;
  wire [3:0]   flen     = m_bit ? LEN9 : LEN8;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tx_st_reg     <= TX_IDLE;
      tsh_reg       <= 11'h7FF;
      tbits_reg     <= 4'h0;
      tos_reg       <= 4'h0;
      te_prev_reg   <= 1'b0;
      idle_pend_reg <= 1'b0;
      tout_reg      <= 1'b1;
      oe_n_reg      <= 1'b1;
    end else begin
      te_prev_reg   <= te;
      oe_n_reg      <= ~te;
      idle_pend_reg <= pre_due & ~tx_pre;
      tout_reg      <= tx_st_reg == TX_RUN ? tsh_reg[0] : 1'b1;
      if (!te) begin
        tx_st_reg <= TX_IDLE;
      end else if (tx_brk || tx_pre || tx_load) begin
        tx_st_reg <= TX_RUN;
        tbits_reg <= flen;
        tos_reg   <= 4'h0;
        tsh_reg   <= tx_brk ? 11'h000 : tx_pre ? 11'h7FF :
                     tx_frame({ctl1_reg[C1_T8], thold_reg[7:0]}, m_bit, ctl1_reg[C1_PC], ctl1_reg[C1_PS]);
      end else if (tx_st_reg == TX_RUN && os_tick[0]) begin
        tos_reg <= tos_reg + 4'h1;
        if (tx_shift) begin
          tsh_reg   <= {1'b1, tsh_reg[10:1]};
          tbits_reg <= tbits_reg - 4'h1;
          if (tx_done) tx_st_reg <= TX_IDLE;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Receiver
  asr_rx_type  rx_st_reg;
  logic [3:0]  ros_reg, rbits_reg;
  logic [8:0]  rsh_reg;
  logic [7:0]  icnt_reg;
  logic        rpc_reg, rps_reg;
  wire         rtick    = os_tick[1];
  wire         rsample  = rtick && ros_reg == OS_LAST;
  wire         rx_done  = rx_en && rx_st_reg == RX_STOP && rsample;
  wire         stop_ok  = rx_in;
  wire [8:0]   word     = m_bit ? rsh_reg : {1'b0, rsh_reg[8:1]};
  // Data MSB sits just below the parity slot when parity is on
  wire         msb      = m_bit ? (rpc_reg ? word[7] : word[8]) : (rpc_reg ? word[6] : word[7]);
  wire         perr     = (m_bit ? par8(word[7:0]) ^ word[8] : par8({1'b0, word[6:0]}) ^ word[7]) ^ rps_reg;
  wire         wake_ad  = rwu_reg && ctl1_reg[C1_WK] && msb;
  wire         accept   = rx_done && (!rwu_reg || wake_ad);
  wire [7:0]   ilim     = m_bit ? IDLE9 : IDLE8;
  wire         idle_ev  = rx_en && rtick && rx_in && icnt_reg == ilim - 8'h01;
  wire         wake_id  = idle_ev && rwu_reg && !ctl1_reg[C1_WK];
  wire         rx_word_ready_flag_set = accept && !rx_word_ready_flag_reg;
  wire         or_set   = accept && rx_word_ready_flag_reg;
  wire         idle_set = idle_ev && !rwu_reg && armed_reg;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rx_st_reg <= RX_IDLE;
      ros_reg   <= 4'h0;
      rbits_reg <= 4'h0;
      rsh_reg   <= 9'h000;
      icnt_reg  <= 8'h00;
      rpc_reg   <= 1'b0;
      rps_reg   <= 1'b0;
    end else if (!rx_en) begin
      rx_st_reg <= RX_IDLE;
      icnt_reg  <= 8'h00;
    end else if (rtick) begin
      icnt_reg <= !rx_in ? 8'h00 : (icnt_reg == ilim) ? icnt_reg : icnt_reg + 8'h01;
      ros_reg  <= ros_reg + 4'h1;
      case (rx_st_reg)
        RX_IDLE: begin
          ros_reg <= 4'h0;
          if (!rx_in) rx_st_reg <= RX_START;
        end
        RX_START: begin
          if (ros_reg == OS_MID) begin
            ros_reg   <= 4'h0;
            rbits_reg <= 4'h0;
            rpc_reg   <= ctl1_reg[C1_PC];
            rps_reg   <= ctl1_reg[C1_PS];
            rx_st_reg <= rx_in ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: begin
          if (rsample) begin
            rsh_reg   <= {rx_in, rsh_reg[8:1]};
            rbits_reg <= rbits_reg + 4'h1;
            if (rbits_reg == (m_bit ? 4'h8 : 4'h7)) rx_st_reg <= RX_STOP;
          end
        end
        RX_STOP: begin
          if (rsample) rx_st_reg <= RX_IDLE;
        end
        default: rx_st_reg <= RX_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Status flags: a set wins over a clear in the same cycle
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tx_empty_flag_reg  <= STATUS_RESET[7];
      tc_reg    <= STATUS_RESET[6];
      rx_word_ready_flag_reg  <= STATUS_RESET[5];
      idle_reg  <= STATUS_RESET[4];
      or_reg    <= STATUS_RESET[3];
      fe_reg    <= STATUS_RESET[1];
      pe_reg    <= STATUS_RESET[0];
      rhold_reg <= 9'h000;
      thold_reg <= 9'h000;
      tfull_reg <= 1'b0;
      armed_reg <= 1'b1;
      rwu_reg   <= 1'b0;
      irq_reg   <= 1'b0;
    end else begin
      tx_empty_flag_reg  <= tx_load | (tx_empty_flag_reg & ~tx_clr);
      tc_reg    <= tx_done | (tc_reg & ~tx_clr);
      rx_word_ready_flag_reg  <= rx_word_ready_flag_set | (rx_word_ready_flag_reg & ~rx_clr & rx_en);
      idle_reg  <= idle_set | (idle_reg & ~rx_clr & rx_en);
      or_reg    <= or_set | (or_reg & ~rx_clr & rx_en);
      fe_reg    <= (rx_word_ready_flag_set & ~stop_ok) | (fe_reg & ~rx_clr & rx_en);
      pe_reg    <= (rx_word_ready_flag_set & rpc_reg & perr) | (pe_reg & ~rx_clr);
      armed_reg <= rx_word_ready_flag_set | (armed_reg & ~idle_set);
      if (rx_word_ready_flag_set) rhold_reg <= word;
      if (wr && hit_dt) thold_reg <= {1'b0, wb_dat_i[7:0]};
      tfull_reg <= (wr & hit_dt) | (tfull_reg & ~tx_load);
      rwu_reg   <= c2_wr ? wb_dat_i[C2_RWU] : rwu_reg & ~(rx_done & wake_ad) & ~wake_id;
      irq_reg   <= (tx_empty_flag_reg & ctl2_reg[C2_TIE]) | (tc_reg & ctl2_reg[C2_TCI]) |
                   (~rwu_reg & (((rx_word_ready_flag_reg | or_reg) & ctl2_reg[C2_RIE]) | (idle_reg & ctl2_reg[C2_ILI]))) |
                   (~rwu_reg & pe_reg & ctl1_reg[C1_PI]);
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;
  assign tx_out   = tout_reg;
  assign tx_oe_n  = oe_n_reg;
  assign irq_req  = irq_reg;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  property p_status_reset;
    @(posedge sys_clk) $fell(rst) |-> status == STATUS_RESET;
  endproperty
  a_status_reset: assert property (p_status_reset) else $error("status not C0 after reset");

  property p_frame_err;
    @(posedge sys_clk) disable iff (rst) rx_word_ready_flag_set && !stop_ok |=> fe_reg && rx_word_ready_flag_reg && rhold_reg == $past(word);
  endproperty
  a_frame_err: assert property (p_frame_err) else $error("framing error not flagged with data");

  property p_rx_clear;
    @(posedge sys_clk) disable iff (rst) rx_clr && !accept |=> !rx_word_ready_flag_reg && !fe_reg && !or_reg;
  endproperty
  a_rx_clear: assert property (p_rx_clear) else $error("receive flags not cleared");

  property p_mute_quiet;
    @(posedge sys_clk) disable iff (rst) rwu_reg && !wake_ad |=> !$rose(rx_word_ready_flag_reg) && !$rose(idle_reg);
  endproperty
  a_mute_quiet: assert property (p_mute_quiet) else $error("flag set while muted");

  property p_idle_wake;
    @(posedge sys_clk) disable iff (rst) wake_id && !c2_wr |=> !rwu_reg && !$rose(idle_reg);
  endproperty
  a_idle_wake: assert property (p_idle_wake) else $error("idle wake-up wrong");

  property p_addr_wake;
    @(posedge sys_clk) disable iff (rst) rx_done && wake_ad && !rx_word_ready_flag_reg && !c2_wr |=> !rwu_reg && rx_word_ready_flag_reg;
  endproperty
  a_addr_wake: assert property (p_addr_wake) else $error("address wake-up wrong");

  property p_tx_flags;
    @(posedge sys_clk) disable iff (rst) tx_load ##1 (!tx_clr)[*2] |-> tx_empty_flag_reg;
  endproperty
  a_tx_flags: assert property (p_tx_flags) else $error("transmit-empty not set on load");

  property p_overrun;
    @(posedge sys_clk) disable iff (rst) or_set |=> or_reg && $stable(rhold_reg);
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun wrong");

  property p_disable;
    @(posedge sys_clk) disable iff (rst) !rx_en |=> !rx_word_ready_flag_reg && !idle_reg && !or_reg && !fe_reg;
  endproperty
  a_disable: assert property (p_disable) else $error("disable left receive flags");

  property p_addr_msb;
    @(posedge sys_clk) disable iff (rst) rx_done && rwu_reg && ctl1_reg[C1_WK] && rpc_reg &&
      (m_bit ? !word[7] : !word[6]) && !c2_wr |=> rwu_reg && !$rose(rx_word_ready_flag_reg);
  endproperty
  a_addr_msb: assert property (p_addr_msb) else $error("parity bit taken as address mark");

endmodule // asr_top

// >>> sim/asr_remote_node.sv
`timescale 1ns/1ps
module asr_remote_node (
  input  wire logic sys_clk,
  input  wire logic tx_line,
  output logic      rx_line
);
  int         bit_cycles = 16;
  int         got_count  = 0;
  logic [8:0] got_bits;

  initial rx_line = 1'b1;

  ////////////////////////////////////////////////////////////
  // Frame LSB first; a bad stop is low for 5/8 of a bit only
  task automatic send(input logic [8:0] word, input int nbits, input logic stop_ok);
    int dur;
    for (int i = 0; i < nbits + 2; i++) begin
      dur = (i == nbits + 1 && !stop_ok) ? bit_cycles * 5 / 8 : bit_cycles;
      @(posedge sys_clk);
      rx_line <= (i == 0) ? 1'b0 : (i <= nbits) ? word[i-1] : stop_ok;
      repeat (dur - 1) @(posedge sys_clk);
    end
    @(posedge sys_clk);
    rx_line <= 1'b1;
    repeat (bit_cycles - dur) @(posedge sys_clk);
  endtask

  ////////////////////////////////////////////////////////////
  // Mid-bit sampling of 8 data bits and the stop bit
  initial begin
    forever begin
      @(posedge sys_clk);
      if (tx_line === 1'b0) begin
        repeat (bit_cycles / 2) @(posedge sys_clk);
        for (int i = 0; i < 9; i++) begin
          repeat (bit_cycles) @(posedge sys_clk);
          got_bits[i] = tx_line;
        end
        got_count++;
      end
    end
  end
endmodule // asr_remote_node

// >>> sim/tb_asr_top.sv
`timescale 1ns/1ps
module tb_asr_top
  import asr_pkg::*;
;
  logic        sys_clk;
  logic        rst;
  logic        wb_cyc;
  logic        wb_stb;
  logic        wb_we;
  logic [7:0]  wb_adr;
  logic [31:0] wb_dat;
  logic [31:0] wb_rdat;
  logic        wb_ack;
  logic        rx_line;
  logic        tx_line;
  logic        tx_oe_n;
  logic        irq;
  int          errors;
  int          checks_done;
  int          n0;
  logic [8:0]  w;
  logic [2:0]  rxp [4] = '{3'h7, 3'h1, 3'h0, 3'h0};
  logic [7:0]  fine [4] = '{8'h00, 8'h02, 8'h00, 8'h05};
  logic [3:0]  crs [4];

  asr_top uut (.sys_clk(sys_clk), .rst(rst), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
               .wb_sel_i(4'hF), .wb_adr_i(wb_adr), .wb_dat_i(wb_dat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
               .rx_in(rx_line), .tx_out(tx_line), .tx_oe_n(tx_oe_n), .irq_req(irq));
  asr_remote_node node (.sys_clk(sys_clk), .tx_line(tx_line), .rx_line(rx_line));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  ////////////////////////////////////////////////////////////
  task automatic complete_run;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic check8(input string name, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic check1(input string name, input logic exp, input logic got);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %b seen %b", name, exp, got);
    end
  endtask

  // One classic cycle, held until ack is sampled
  task automatic bus(input logic [7:0] adr, input logic we, input logic [7:0] wd, output logic [7:0] rd);
    int n;
    n = 0;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we  <= we;
    wb_adr <= adr;
    wb_dat <= {24'h0, wd};
    do begin
      @(posedge sys_clk);
      n++;
    end while (wb_ack !== 1'b1 && n < 20);
    if (n >= 20) begin
      errors++;
      complete_run();
    end
    rd = wb_rdat[7:0];
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic wr(input logic [7:0] adr, input logic [7:0] d);
    logic [7:0] x;
    bus(adr, 1'b1, d, x);
  endtask

  task automatic expect_reg(input string name, input logic [7:0] adr, input logic [7:0] mask, input logic [7:0] exp);
    logic [7:0] x;
    bus(adr, 1'b0, 8'h00, x);
    check8(name, exp, x & mask);
  endtask

  task automatic gap(input int bits);
    repeat (bits * node.bit_cycles) @(posedge sys_clk);
  endtask

  function automatic logic par_of(input logic [8:0] d, input logic nine, input logic odd);
    return (nine ? ^d[7:0] : ^d[6:0]) ^ odd;
  endfunction

  ////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    wb_cyc = 1'b0;
    wb_stb = 1'b0;
    wb_we = 1'b0;
    wb_adr = 8'h00;
    wb_dat = 32'h0;
    errors = 0;
    checks_done = 0;
    crs = '{COARSE_0, COARSE_1, COARSE_2, COARSE_3};
    void'($urandom(22936));
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    expect_reg("status reset", ADDR_STATUS, 8'hFF, STATUS_RESET);
    wr(ADDR_STATUS, 8'h3F);
    expect_reg("status ro", ADDR_STATUS, 8'hFF, STATUS_RESET);
    expect_reg("unmapped", 8'h10, 8'hFF, 8'h00);
    for (int k = 0; k < 4; k++) begin
      wr(ADDR_CTL2, 8'h00);
      wr(ADDR_BAUD, {k[1:0], 3'h0, rxp[k]});
      wr(ADDR_RXFINE, fine[k]);
      wr(ADDR_CTL2, 8'h04);
      node.bit_cycles = 16 * int'(crs[k]) * (1 << rxp[k]) * (fine[k] == 8'h00 ? 1 : int'(fine[k]));
      w = 9'($urandom);
      node.send(w, 8, 1'b1);
      expect_reg("rate flags", ADDR_STATUS, 8'h2B, 8'h20);
      expect_reg("rate data", ADDR_DATA, 8'hFF, w[7:0]);
    end
    wr(ADDR_CTL2, 8'h00);
    wr(ADDR_BAUD, 8'h00);
    wr(ADDR_RXFINE, 8'h00);
    node.bit_cycles = 16;
    wr(ADDR_CTL2, 8'h24);
    w = 9'($urandom);
    node.send(w, 8, 1'b0);
    check1("irq rx", 1'b1, irq);
    expect_reg("framing", ADDR_STATUS, 8'h2B, 8'h22);
    expect_reg("ctl1", ADDR_CTL1, 8'hFF, 8'h00);
    expect_reg("framing data", ADDR_DATA, 8'hFF, w[7:0]);
    expect_reg("broken clear", ADDR_STATUS, 8'h2B, 8'h22);
    expect_reg("data", ADDR_DATA, 8'hFF, w[7:0]);
    expect_reg("cleared", ADDR_STATUS, 8'h2B, 8'h00);
    w = 9'($urandom);
    node.send(w, 8, 1'b1);
    node.send(9'($urandom), 8, 1'b1);
    expect_reg("overrun", ADDR_STATUS, 8'h2B, 8'h28);
    expect_reg("kept data", ADDR_DATA, 8'hFF, w[7:0]);
    node.send(9'($urandom), 8, 1'b1);
    wr(ADDR_CTL2, 8'h00);
    expect_reg("rx off", ADDR_STATUS, 8'h3F, 8'h00);
    for (int k = 0; k < 4; k++) begin
      wr(ADDR_CTL1, 8'h05 | (8'(k[0]) << C1_PS) | (8'(k[1]) << C1_M));
      wr(ADDR_CTL2, 8'h04);
      for (int g = 0; g < 2; g++) begin
        w = 9'($urandom);
        if (k[1]) w[8] = par_of(w, 1'b1, k[0]) ^ (g == 0);
        else w[7] = par_of(w, 1'b0, k[0]) ^ (g == 0);
        node.send(w, 8 + int'(k[1]), 1'b1);
        check1("irq parity", g == 0, irq);
        expect_reg("parity", ADDR_STATUS, 8'h2B, (g == 0) ? 8'h21 : 8'h20);
        expect_reg("parity data", ADDR_DATA, 8'hFF, w[7:0]);
      end
    end
    wr(ADDR_CTL1, 8'h1C);
    wr(ADDR_CTL2, 8'h26);
    w = {1'b1, 1'b0, 7'($urandom)};
    node.send(w, 9, 1'b1);
    check1("irq muted", 1'b0, irq);
    expect_reg("muted", ADDR_STATUS, 8'h3F, 8'h00);
    w = {1'b0, 1'b1, 7'($urandom)};
    w[8] = par_of(w, 1'b1, 1'b0);
    node.send(w, 9, 1'b1);
    expect_reg("woken", ADDR_CTL2, 8'hFF, 8'h24);
    expect_reg("address", ADDR_STATUS, 8'h2B, 8'h20);
    expect_reg("address data", ADDR_DATA, 8'hFF, w[7:0]);
    wr(ADDR_CTL1, 8'h00);
    wr(ADDR_CTL2, 8'h06);
    node.send(9'($urandom), 8, 1'b1);
    gap(12);
    expect_reg("idle wake", ADDR_CTL2, 8'hFF, 8'h04);
    expect_reg("no idle", ADDR_STATUS, 8'h3F, 8'h00);
    w = 9'($urandom);
    node.send(w, 8, 1'b1);
    gap(12);
    expect_reg("idle", ADDR_STATUS, 8'h3B, 8'h30);
    expect_reg("data", ADDR_DATA, 8'hFF, w[7:0]);
    gap(12);
    expect_reg("idle once", ADDR_STATUS, 8'h3F, 8'h00);
    wr(ADDR_CTL2, 8'h00);
    wr(ADDR_BAUD, 8'h08);
    wr(ADDR_CTL1, 8'h04);
    node.bit_cycles = 32;
    wr(ADDR_CTL2, 8'h48);
    gap(12);
    check1("tx enabled", 1'b0, tx_oe_n);
    check1("irq preamble", 1'b1, irq);
    expect_reg("tx idle", ADDR_STATUS, 8'hC0, 8'hC0);
    w = 9'($urandom);
    n0 = node.got_count;
    wr(ADDR_DATA, w[7:0]);
    expect_reg("tc cleared", ADDR_STATUS, 8'hC0, 8'h80);
    check1("irq busy", 1'b0, irq);
    for (int i = 0; i < 1000 && node.got_count == n0; i++) @(posedge sys_clk);
    if (node.got_count == n0) begin
      errors++;
      complete_run();
    end
    check8("tx word", {par_of(w, 1'b0, 1'b0), w[6:0]}, node.got_bits[7:0]);
    check1("tx stop", 1'b1, node.got_bits[8]);
    gap(1);
    check1("irq done", 1'b1, irq);
    expect_reg("tc set", ADDR_STATUS, 8'hC0, 8'hC0);
    complete_run();
  end
endmodule // tb_asr_top
